// [inc/alts_consts.vh]
// Constants of the arm layer trigger sequencer: register offsets,
// field positions, reset values, source codes and pulse timing.
// Assumes inclusion by bare name from the rtl files.
`ifndef ALTS_CONSTS_VH
`define ALTS_CONSTS_VH

// Register byte offsets on the APB bus
`define ALTS_OFS_CTRL   8'h00
`define ALTS_OFS_COUNT  8'h04
`define ALTS_OFS_LINES  8'h08
`define ALTS_OFS_CMD    8'h0C
`define ALTS_OFS_STAT   8'h10

// Control register fields
`define ALTS_CTRL_SRC_LSB   0
`define ALTS_CTRL_ABYP      3
`define ALTS_CTRL_SBYP      4
`define ALTS_CTRL_SEXT      5
`define ALTS_CTRL_MSRC_LSB  6
`define ALTS_CTRL_INF       9

// Line select fields, command bits, status fields
`define ALTS_LINES_IN_LSB   0
`define ALTS_LINES_OUT_LSB  4
`define ALTS_CMD_INIT       0
`define ALTS_CMD_HALT       1
`define ALTS_STAT_PASS_LSB  4

// Arm source codes
`define ALTS_SRC_IMM    3'h0
`define ALTS_SRC_EXT    3'h1
`define ALTS_SRC_MAN    3'h2
`define ALTS_SRC_BUS    3'h3
`define ALTS_SRC_LINE   3'h4
`define ALTS_SRC_HOLD   3'h5

// Measure source codes; codes up to MSRC_MAN emit completion
`define ALTS_MSRC_IMM   3'h0
`define ALTS_MSRC_MAN   3'h3

// Reset values and the arm count maximum
`define ALTS_RST_SRC    3'h0
`define ALTS_RST_MSRC   3'h0
`define ALTS_RST_COUNT  17'h00001
`define ALTS_RST_IN     3'h2
`define ALTS_RST_OUT    3'h1
`define ALTS_COUNT_MAX  17'h1869F

// Completion pulse width in ns and clock period in ns
`define ALTS_PULSE_NS   10000
`define ALTS_CLK_NS     10
`define ALTS_PULSE_CYC  ((`ALTS_PULSE_NS + `ALTS_CLK_NS - 1) / `ALTS_CLK_NS)

`endif

// [rtl/alts_edge_sync.v]
// Two-stage synchroniser with falling-edge detect for pin inputs.
// Assumes asynchronous low-going trigger pulses at the inputs.
`timescale 1ns/1ns
`default_nettype none

module alts_edge_sync #(
	parameter W = 8
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] pin_d,
	output wire [W-1:0] fall
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	reg [W-1:0] last_q;

	// Sync chain, idle level high
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= {W{1'b1}};
			sync_q <= {W{1'b1}};
			last_q <= {W{1'b1}};
		end else begin
			meta_q <= pin_d;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// One-cycle pulse on high-to-low
	assign fall = last_q & ~sync_q;

endmodule // alts_edge_sync

`default_nettype wire

// [rtl/alts_pulse_gen.v]
// Low-going completion pulse generator of fixed width.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ns
`default_nettype none

module alts_pulse_gen #(
	parameter WIDTH = 1000
) (
	input  wire clk,
	input  wire rst_n,
	input  wire start,
	output wire busy,
	output wire pulse_n
);

	reg [15:0] cnt_q;
	reg        out_n_q;

	// Load on start when idle, count down to release
	always @(posedge clk) begin
		if (!rst_n) begin
			cnt_q   <= 16'h0000;
			out_n_q <= 1'b1;
		end else if (start && cnt_q == 16'h0000) begin
			cnt_q   <= WIDTH[15:0];
			out_n_q <= 1'b0;
		end else if (cnt_q != 16'h0000) begin
			cnt_q   <= cnt_q - 16'h0001;
			out_n_q <= (cnt_q == 16'h0001);
		end
	end

	assign busy    = (cnt_q != 16'h0000);
	assign pulse_n = out_n_q;

endmodule // alts_pulse_gen

`default_nettype wire

// [rtl/alts_top.v]
// Arm layer trigger sequencer with external trigger input, six-line
// pulse bus and completion pulse output, APB register access.
// Assumes scan and measure layers sit outside on the same clock.
//
// Function
// - With bus source, the fire key also advances into the scan layer.
// - Line bus source advances on a trigger at the selected input line.
// - With line bus source, the fire key also advances.
// - Input and output lines range 1..6 and may not be equal.
// - Hold source never yields an arm event.
// - Arm count is infinite or 1..99999, default one.
// - Infinite count loops back to the arm layer forever.
// - Source bypass skips the arm wait on the first pass only.
// - Halt disarms to idle; a later fire key press resumes.
// - External triggers are recognised on the falling edge.
// - External pulse only advances a layer whose source is external.
// - Completion pulse after each measurement for ext/timer/manual/immediate.
// - Scan bypass with external scan source pulses on each scan loop.
// - Arm bypass with external arm source pulses on each arm return.
// - Out of reset the sequencer is armed and passes straight down.
// - Completion follows the reading being taken and stored.
// - Immediate source passes into the scan layer at once.
// - Manual source passes only on a fire key press.
// - External source advances on the pulse; fire key stays active.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "alts_consts.vh"

module alts_top #(
	parameter PULSE_CYC = `ALTS_PULSE_CYC
) (
	input  wire        REF_CLK,
	input  wire        RESETN,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        EXT_FRONT_PANEL_FIRE_KEY_N,
	input  wire        FIRE_KEY_N,
	input  wire        BUS_FRONT_PANEL_FIRE_KEY,
	input  wire [5:0]  LINE_IN,
	output reg  [5:0]  LINE_OUT,
	output reg  [5:0]  LINE_OE,
	output wire        COMPLETE_N,
	output reg         SCAN_GO,
	output wire        ARMED,
	input  wire        SCAN_RETURN,
	input  wire        SCAN_LOOP,
	input  wire        MEAS_DONE
);

	// Sequencer states
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_SCAN = 2'b10;

	// Configuration registers
	reg  [2:0]  src_q;
	reg         abyp_q;
	reg         sbyp_q;
	reg         sext_q;
	reg  [2:0]  msrc_q;
	reg         inf_q;
	reg  [16:0] count_q;
	reg  [2:0]  in_line_q;
	reg  [2:0]  out_line_q;

	// Sequencer state
	reg  [1:0]  state_q;
	reg  [1:0]  state_d;
	reg         first_q;
	reg         first_d;
	reg  [16:0] pass_q;
	reg  [16:0] pass_d;

	// Bus decode
	wire        acc;
	wire        wr;
	wire        hit_ctrl;
	wire        hit_count;
	wire        hit_lines;
	wire        hit_cmd;
	wire        hit_stat;
	wire        mapped;
	wire        bad_count;
	wire        bad_lines;
	wire [2:0]  wr_in;
	wire [2:0]  wr_out;
	wire [16:0] wr_count;

	// Events
	wire [7:0]  fall;
	wire        ext_fall;
	wire        key_fall;
	wire        line_hit;
	wire        halt_cmd;
	wire        init_cmd;
	reg         arm_event;
	wire        arm_return;
	wire        last_pass;
	wire        cmpl_start;
	wire        pulse_busy;

	// One-hot mask of a line number 1..6, zero otherwise
	function [5:0] line_mask;
		input [2:0] sel;
		begin
			case (sel)
				3'h1: line_mask = 6'h01;
				3'h2: line_mask = 6'h02;
				3'h3: line_mask = 6'h04;
				3'h4: line_mask = 6'h08;
				3'h5: line_mask = 6'h10;
				3'h6: line_mask = 6'h20;
				default: line_mask = 6'h00;
			endcase
		end
	endfunction

	// A legal pair of distinct lines
	function line_pair_ok;
		input [2:0] li;
		input [2:0] lo;
		begin
			line_pair_ok = (line_mask(li) != 6'h00) && (line_mask(lo) != 6'h00) && (li != lo);
		end
	endfunction

	// Pin inputs through the synchroniser
	alts_edge_sync #(
		.W(8)
	) u_sync (
		.clk    (REF_CLK),
		.rst_n  (RESETN),
		.pin_d  ({FIRE_KEY_N, EXT_FRONT_PANEL_FIRE_KEY_N, LINE_IN}),
		.fall   (fall)
	);

	assign ext_fall = fall[6];
	assign key_fall = fall[7];
	assign line_hit = |(fall[5:0] & line_mask(in_line_q));

	// APB decode; zero wait states
	assign acc       = PSEL & PENABLE;
	assign wr        = acc & PWRITE;
	assign hit_ctrl  = (PADDR == `ALTS_OFS_CTRL);
	assign hit_count = (PADDR == `ALTS_OFS_COUNT);
	assign hit_lines = (PADDR == `ALTS_OFS_LINES);
	assign hit_cmd   = (PADDR == `ALTS_OFS_CMD);
	assign hit_stat  = (PADDR == `ALTS_OFS_STAT);
	assign mapped    = hit_ctrl | hit_count | hit_lines | hit_cmd | hit_stat;
	assign wr_count  = PWDATA[16:0];
	assign wr_in     = PWDATA[`ALTS_LINES_IN_LSB +: 3];
	assign wr_out    = PWDATA[`ALTS_LINES_OUT_LSB +: 3];
	assign bad_count = (wr_count == 17'h00000) || (wr_count > `ALTS_COUNT_MAX) || (PWDATA[31:17] != 15'h0000);
	assign bad_lines = !line_pair_ok(wr_in, wr_out);
	assign PREADY    = 1'b1;
	assign PSLVERR   = acc & (!mapped | (PWRITE & hit_count & bad_count) | (PWRITE & hit_lines & bad_lines)
	                   | (PWRITE & hit_stat));

	// Command strobes from the write-only command register
	assign halt_cmd = wr & hit_cmd & PWDATA[`ALTS_CMD_HALT];
	assign init_cmd = wr & hit_cmd & PWDATA[`ALTS_CMD_INIT];

	// Configuration writes; illegal values leave the register unchanged
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			src_q      <= `ALTS_RST_SRC;
			abyp_q     <= 1'b0;
			sbyp_q     <= 1'b0;
			sext_q     <= 1'b0;
			msrc_q     <= `ALTS_RST_MSRC;
			inf_q      <= 1'b0;
			count_q    <= `ALTS_RST_COUNT;
			in_line_q  <= `ALTS_RST_IN;
			out_line_q <= `ALTS_RST_OUT;
		end else if (wr) begin
			if (hit_ctrl) begin
				src_q  <= PWDATA[`ALTS_CTRL_SRC_LSB +: 3];
				abyp_q <= PWDATA[`ALTS_CTRL_ABYP];
				sbyp_q <= PWDATA[`ALTS_CTRL_SBYP];
				sext_q <= PWDATA[`ALTS_CTRL_SEXT];
				msrc_q <= PWDATA[`ALTS_CTRL_MSRC_LSB +: 3];
				inf_q  <= PWDATA[`ALTS_CTRL_INF];
			end
			if (hit_count && !bad_count) begin
				count_q <= wr_count;
			end
			if (hit_lines && !bad_lines) begin
				in_line_q  <= wr_in;
				out_line_q <= wr_out;
			end
		end
	end

	// Read data captured in the setup phase
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			PRDATA <= 32'h00000000;
		end else if (PSEL && !PENABLE) begin
			case (PADDR)
				`ALTS_OFS_CTRL:  PRDATA <= {22'h000000, inf_q, msrc_q, sext_q, sbyp_q, abyp_q, src_q};
				`ALTS_OFS_COUNT: PRDATA <= {15'h0000, count_q};
				`ALTS_OFS_LINES: PRDATA <= {25'h0000000, out_line_q, 1'b0, in_line_q};
				`ALTS_OFS_STAT:  PRDATA <= {11'h000, pass_q, 1'b0, first_q, state_q};
				default:         PRDATA <= 32'h00000000;
			endcase
		end
	end

	// Arm event per selected source
	always @* begin
		case (src_q)
			`ALTS_SRC_IMM:  arm_event = 1'b1;
			`ALTS_SRC_EXT:  arm_event = ext_fall | key_fall;
			`ALTS_SRC_MAN:  arm_event = key_fall;
			`ALTS_SRC_BUS:  arm_event = BUS_FRONT_PANEL_FIRE_KEY | key_fall;
			`ALTS_SRC_LINE: arm_event = line_hit | key_fall;
			`ALTS_SRC_HOLD: arm_event = 1'b0;
			default:        arm_event = 1'b0;
		endcase
	end

	// Pass bookkeeping
	assign arm_return = (state_q == ST_SCAN) && SCAN_RETURN;
	assign last_pass  = !inf_q && ((pass_q + 17'h00001) >= count_q);

	// Arm layer state machine
	always @* begin
		state_d = state_q;
		first_d = first_q;
		pass_d  = pass_q;
		SCAN_GO = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (key_fall || init_cmd) begin
					state_d = ST_WAIT;
					first_d = 1'b1;
					pass_d  = 17'h00000;
				end
			end
			ST_WAIT: begin
				if ((first_q && abyp_q) || arm_event) begin
					state_d = ST_SCAN;
					first_d = 1'b0;
					SCAN_GO = 1'b1;
				end
			end
			ST_SCAN: begin
				if (SCAN_RETURN) begin
					if (last_pass) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_WAIT;
						pass_d  = pass_q + 17'h00001;
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (halt_cmd) begin
			state_d = ST_IDLE;
			SCAN_GO = 1'b0;
		end
	end

	// Reset lands armed, first pass pending
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			state_q <= ST_WAIT;
			first_q <= 1'b1;
			pass_q  <= 17'h00000;
		end else begin
			state_q <= state_d;
			first_q <= first_d;
			pass_q  <= pass_d;
		end
	end

	assign ARMED = (state_q != ST_IDLE);

	// Completion sources
	assign cmpl_start = (MEAS_DONE && (msrc_q <= `ALTS_MSRC_MAN))
	                  | (SCAN_LOOP && sbyp_q && sext_q)
	                  | (arm_return && abyp_q && (src_q == `ALTS_SRC_EXT));

	// Completion pulse shaper
	alts_pulse_gen #(
		.WIDTH(PULSE_CYC)
	) u_pulse (
		.clk     (REF_CLK),
		.rst_n   (RESETN),
		.start   (cmpl_start),
		.busy    (pulse_busy),
		.pulse_n (COMPLETE_N)
	);

	// Same pulse pulls the selected output line low
	always @(posedge REF_CLK) begin
		if (!RESETN) begin
			LINE_OUT <= 6'h00;
			LINE_OE  <= 6'h00;
		end else begin
			LINE_OUT <= 6'h00;
			LINE_OE  <= (pulse_busy || (cmpl_start && !pulse_busy)) ? line_mask(out_line_q) : 6'h00;
		end
	end

endmodule // alts_top

`default_nettype wire

// [dv/alts_scanner.sv]
// Scanner model: closes a channel, lets it settle, sends a ready pulse.
// Assumes the meter completion pulse on done_n, same clock.
`timescale 1ns/1ns
`default_nettype none
module alts_scanner #(
	parameter SETTLE = 6
) (
	input  wire logic clk,
	input  wire logic start,
	input  wire logic done_n,
	output var logic  ready_n,
	output var int    n_ch
);
	logic done_q = 1'b1;
	int   cnt_q  = 0;
	initial ready_n = 1'b1;
	initial n_ch = 0;
	// Close a channel on start or meter complete, settle, pulse low
	always @(posedge clk) begin
		done_q <= done_n;
		if (start || (done_q && !done_n)) begin
			cnt_q <= SETTLE + 4;
			n_ch  <= n_ch + 1;
		end else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
		ready_n <= !(cnt_q != 0 && cnt_q <= 4);
	end
endmodule // alts_scanner
`default_nettype wire

// [dv/alts_asserts.sv]
// Checker of the sequencer top: bus refusals, arm flow, completion pulse.
// Assumes binding into alts_top by its port names.
`timescale 1ns/1ns
`default_nettype none
module alts_asserts #(
	parameter PULSE_CYC = 4
) (
	input wire logic        REF_CLK,
	input wire logic        RESETN,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PSLVERR,
	input wire logic        COMPLETE_N,
	input wire logic [5:0]  LINE_OE,
	input wire logic        SCAN_GO,
	input wire logic        ARMED,
	input wire logic        SCAN_RETURN,
	input wire logic        SCAN_LOOP,
	input wire logic        MEAS_DONE
);
	logic        halt_q;
	logic        cause_q;
	logic        ret_q;
	logic [15:0] low_q;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESETN);
	// Causes seen one cycle back, and length of the low pulse
	always_ff @(posedge REF_CLK) begin
		if (!RESETN) begin
			halt_q  <= 1'b0;
			cause_q <= 1'b0;
			ret_q   <= 1'b0;
			low_q   <= 16'h0000;
		end else begin
			halt_q  <= PSEL && PENABLE && PWRITE && PADDR == 8'h0C && PWDATA[1];
			cause_q <= MEAS_DONE || SCAN_LOOP || SCAN_RETURN;
			ret_q   <= SCAN_RETURN;
			low_q   <= COMPLETE_N ? 16'h0000 : low_q + 16'h0001;
		end
	end
	sequence s_acc;
		PSEL && PENABLE;
	endsequence
	sequence s_go;
		SCAN_GO ##1 !SCAN_GO;
	endsequence
	a_lines_same: assert property (s_acc ##0 (PWRITE && PADDR == 8'h08 && PWDATA[2:0] == PWDATA[6:4]) |-> PSLVERR)
		else $error("equal lines accepted");
	a_count_zero: assert property (s_acc ##0 (PWRITE && PADDR == 8'h04 && PWDATA == 32'h0) |-> PSLVERR)
		else $error("zero count accepted");
	a_arm_drop: assert property ($fell(ARMED) |-> halt_q || ret_q)
		else $error("disarmed without cause");
	a_go_armed: assert property (SCAN_GO |-> ARMED)
		else $error("advance while idle");
	a_go_single: assert property (RESETN && SCAN_GO |-> s_go)
		else $error("advance longer than a cycle");
	a_cmpl_cause: assert property ($fell(COMPLETE_N) |-> cause_q)
		else $error("completion without cause");
	a_cmpl_width: assert property ($rose(COMPLETE_N) |-> low_q == PULSE_CYC)
		else $error("completion width wrong");
	a_cmpl_line: assert property ($fell(COMPLETE_N) |-> $onehot(LINE_OE))
		else $error("output line not driven");
endmodule // alts_asserts
bind alts_top alts_asserts #(.PULSE_CYC(PULSE_CYC)) i_chk (.REF_CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PSLVERR, .COMPLETE_N, .LINE_OE, .SCAN_GO, .ARMED, .SCAN_RETURN, .SCAN_LOOP, .MEAS_DONE);
`default_nettype wire

// [dv/test_alts_top.sv]
// Bench of the sequencer top: arm sources, counts, halt, completion.
// Assumes the scanner model on the trigger pin and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`include "alts_consts.vh"
module test_alts_top;
	logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, x, ext_n = 1, key_n = 1, btrig = 0;
	logic        use_scn = 0, scn_start = 0, scn_n, e_q = 1, md_q = 0, meas_en = 0;
	logic        scn_go, armed, cmpl_n;
	logic [5:0]  line_in = 6'h3F, line_oe, line_out;
	logic [2:0]  kick = 3'h0;
	int          n_mismatch = 0, compares = 0, n_ch, i, j;
	// Rows: arm source, event (1 pin, 2 key, 3 bus, 4 line), pass expected
	logic [6:0]  tab [13] = '{7'h01, 7'h13, 7'h15, 7'h16, 7'h25, 7'h22, 7'h37, 7'h35, 7'h49, 7'h45, 7'h42, 7'h54,
		7'h52};
	wire         front_panel_fire_key_n = use_scn ? scn_n : ext_n;
	alts_top #(.PULSE_CYC(4)) i_dut (.REF_CLK(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EXT_FRONT_PANEL_FIRE_KEY_N(front_panel_fire_key_n),
		.FIRE_KEY_N(key_n), .BUS_FRONT_PANEL_FIRE_KEY(btrig), .LINE_IN(line_in), .LINE_OUT(line_out), .LINE_OE(line_oe),
		.COMPLETE_N(cmpl_n), .SCAN_GO(scn_go), .ARMED(armed), .SCAN_RETURN(kick[0]), .SCAN_LOOP(kick[1]),
		.MEAS_DONE(kick[2] | md_q));
	alts_scanner #(.SETTLE(6)) i_scn (.clk(clk), .start(scn_start), .done_n(cmpl_n), .ready_n(scn_n), .n_ch(n_ch));
	initial forever #5 clk = ~clk;
	// Measure layer stand-in: reading done one cycle after the ready pulse falls
	always @(posedge clk) begin
		e_q  <= front_panel_fire_key_n;
		md_q <= meas_en && e_q && !front_panel_fire_key_n;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("compares %0d, n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One bus transfer, held until ready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (k = 0; k < 16 && !(pen && pready); k++)
			@(posedge clk);
		r = prdata;
		x = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		if (k == 16) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
		apb(1'b1, a, d);
		chk(x, e);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0);
		chk(r, d);
	endtask
	// Apply one arm event and watch for the pass into the scan layer
	task automatic fire(input logic [2:0] ev, input logic g);
		logic s;
		s = 1'b0;
		for (int k = 0; k < 12; k++) begin
			#1 s = s | scn_go;
			@(posedge clk);
			ext_n   <= !(ev == 3'h1 && k < 5);
			key_n   <= !(ev == 3'h2 && k < 5);
			btrig   <= ev == 3'h3 && k == 0;
			line_in <= (ev == 3'h4 && k < 5) ? 6'h3D : 6'h3F;
		end
		chk(s, g);
	endtask
	// Pulse return/loop/done and watch the completion output
	task automatic cmpl(input logic [2:0] k3, input logic [5:0] eo);
		logic       s;
		logic [5:0] oe;
		s = 1'b0;
		oe = 6'h00;
		@(posedge clk);
		kick <= k3;
		@(posedge clk);
		kick <= 3'h0;
		for (int k = 0; k < 8; k++) begin
			#1 s = s | !cmpl_n;
			if (!cmpl_n)
				oe = line_oe;
			@(posedge clk);
		end
		chk(s, eo != 6'h00);
		chk(oe, eo);
		chk(line_out, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(`ALTS_OFS_CTRL, 32'h0);
		rd(`ALTS_OFS_COUNT, 32'h1);
		rd(`ALTS_OFS_LINES, 32'h12);
		rd(`ALTS_OFS_CMD, 32'h0);
		chk(armed, 1'b1);
		use_scn <= 1'b1;
		meas_en <= 1'b1;
		scn_start <= 1'b1;
		@(posedge clk);
		scn_start <= 1'b0;
		for (i = 0; i < 3000 && n_ch < 10; i++)
			@(posedge clk);
		chk(n_ch, 32'd10);
		if (n_ch < 10)
			conclude();
		use_scn <= 1'b0;
		meas_en <= 1'b0;
		repeat (30) @(posedge clk);
		for (j = 0; j < 13; j++) begin
			wr(`ALTS_OFS_CMD, 32'h2, 1'b0);
			wr(`ALTS_OFS_CTRL, {29'h0, tab[j][6:4]}, 1'b0);
			wr(`ALTS_OFS_CMD, 32'h1, 1'b0);
			fire(tab[j][3:1], tab[j][0]);
			cmpl(3'h1, 6'h00);
		end
		wr(`ALTS_OFS_COUNT, 32'h0, 1'b1);
		wr(`ALTS_OFS_COUNT, 32'h186A0, 1'b1);
		wr(`ALTS_OFS_COUNT, 32'h1869F, 1'b0);
		rd(`ALTS_OFS_COUNT, 32'h1869F);
		wr(`ALTS_OFS_LINES, 32'h22, 1'b1);
		wr(`ALTS_OFS_LINES, 32'h17, 1'b1);
		wr(`ALTS_OFS_LINES, 32'h63, 1'b0);
		rd(`ALTS_OFS_LINES, 32'h63);
		wr(`ALTS_OFS_STAT, 32'h0, 1'b1);
		wr(8'h40, 32'h0, 1'b1);
		rd(8'h40, 32'h0);
		for (j = 0; j < 7; j++) begin
			wr(`ALTS_OFS_CTRL, j << 6, 1'b0);
			cmpl(3'h4, j < 4 ? 6'h20 : 6'h00);
		end
		wr(`ALTS_OFS_CTRL, 32'h30, 1'b0);
		cmpl(3'h2, 6'h20);
		wr(`ALTS_OFS_CTRL, 32'h20, 1'b0);
		cmpl(3'h2, 6'h00);
		wr(`ALTS_OFS_CMD, 32'h2, 1'b0);
		wr(`ALTS_OFS_CTRL, 32'h209, 1'b0);
		wr(`ALTS_OFS_CMD, 32'h1, 1'b0);
		fire(3'h0, 1'b1);
		cmpl(3'h1, 6'h20);
		fire(3'h0, 1'b0);
		fire(3'h1, 1'b1);
		wr(`ALTS_OFS_COUNT, 32'h3, 1'b0);
		wr(`ALTS_OFS_CMD, 32'h2, 1'b0);
		wr(`ALTS_OFS_CTRL, 32'h0, 1'b0);
		wr(`ALTS_OFS_CMD, 32'h1, 1'b0);
		for (j = 0; j < 3; j++) begin
			cmpl(3'h1, 6'h00);
			chk(armed, j < 2);
		end
		// Idle after the third pass, two passes counted
		rd(`ALTS_OFS_STAT, 32'h20);
		wr(`ALTS_OFS_CTRL, 32'h200, 1'b0);
		wr(`ALTS_OFS_CMD, 32'h1, 1'b0);
		for (j = 0; j < 4; j++)
			cmpl(3'h1, 6'h00);
		chk(armed, 1'b1);
		// Still scanning, four passes counted, bypass spent
		rd(`ALTS_OFS_STAT, 32'h42);
		wr(`ALTS_OFS_CMD, 32'h3, 1'b0);
		// Let the halt settle past the access edge
		#1;
		chk(armed, 1'b0);
		fire(3'h2, 1'b1);
		chk(armed, 1'b1);
		conclude();
	end
endmodule // test_alts_top
`default_nettype wire
